// File: logic/hiclk_pkg.sv
package hiclk_pkg;

   // ------------------------------------------------------------
   // Bus shape
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_SERIRQ = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_POLICY = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int IRQ_BIT    = 0;
   localparam int HS_BIT     = 2;
   localparam int POL_LSB    = 0;
   localparam int POL_MSB    = 1;
   localparam int ST_PERMIT  = 0;
   localparam int ST_CLKSTOP = 1;
   localparam int ST_PWRDN   = 2;
   localparam int ST_BUSY    = 3;
   localparam int ST_WAKE    = 4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic       RST_IRQ = 1'b0;
   localparam logic       RST_HS  = 1'b1;
   localparam logic [1:0] RST_POL = 2'h0;

   // ------------------------------------------------------------
   // Shutdown policy codes
   // ------------------------------------------------------------
   localparam logic [1:0] POL_PWRDN  = 2'h0;
   localparam logic [1:0] POL_CLKRUN = 2'h1;
   localparam logic [1:0] POL_TXN    = 2'h2;
   localparam logic [1:0] POL_NEVER  = 2'h3;

   // ------------------------------------------------------------
   // Timing, in bus clock cycles
   // ------------------------------------------------------------
   localparam logic [2:0] CLKSTOP_CYCLES = 3'h5;

endpackage

// File: logic/hiclk_sync3.sv
`timescale 1ns/1ns
module hiclk_sync3 (
   input  wire logic clk_i,   // Destination clock
   input  wire logic rst_i,   // Synchronous reset, active high
   input  wire logic d_i,     // Level from another domain
   output logic      q_o      // Filtered level
);

   logic s1_r;
   logic s2_r;
   logic s3_r;

   // s1_r feeds only s2_r; output moves once s2 and s3 agree
   always_ff @(posedge clk_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= 1'b0;
      end else if (s2_r == s3_r) begin
         q_o <= s3_r;
      end
   end

endmodule

// File: logic/hiclk_link.sv
`timescale 1ns/1ns
module hiclk_link
   import hiclk_pkg::*;
(
   input  wire logic lclk_i,        // Bus clock
   input  wire logic lrst_i,        // Reset in bus clock domain
   input  wire logic clkrun_n_i,    // Clock run line, bus clock timed
   input  wire logic cyc_start_i,   // Bus cycle detected, pulse
   input  wire logic cyc_done_i,    // Bus cycle completed, pulse
   input  wire logic osc_off_i,     // Oscillator stopped, async level
   output logic      clkstop_o,     // Clock stop seen, level
   output logic      start_tgl_o,   // Toggles per cycle start
   output logic      done_tgl_o,    // Toggles per cycle end
   output logic      wake_o         // Host wake request, level
);

   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic       off_s;
   logic       clkrun_q_r;

   // ------------------------------------------------------------
   // Clock stop detection
   // ------------------------------------------------------------
   always_comb begin
      if (!clkrun_n_i) begin
         cnt_nxt = 3'h0;
      end else if (cnt_r == CLKSTOP_CYCLES) begin
         cnt_nxt = cnt_r;
      end else begin
         cnt_nxt = cnt_r + 3'h1;
      end
   end

   always_ff @(posedge lclk_i) begin
      if (lrst_i) begin
         cnt_r      <= 3'h0;
         clkstop_o  <= 1'b0;
         clkrun_q_r <= 1'b0;
      end else begin
         cnt_r      <= cnt_nxt;
         clkstop_o  <= (cnt_nxt == CLKSTOP_CYCLES);
         clkrun_q_r <= clkrun_n_i;
      end
   end

   // ------------------------------------------------------------
   // Cycle events toward the controller clock
   // ------------------------------------------------------------
   always_ff @(posedge lclk_i) begin
      if (lrst_i) begin
         start_tgl_o <= 1'b0;
         done_tgl_o  <= 1'b0;
      end else begin
         start_tgl_o <= start_tgl_o ^ cyc_start_i;
         done_tgl_o  <= done_tgl_o ^ cyc_done_i;
      end
   end

   // ------------------------------------------------------------
   // Wake request
   // ------------------------------------------------------------
   hiclk_sync3 u_off (
      .clk_i (lclk_i),
      .rst_i (lrst_i),
      .d_i   (osc_off_i),
      .q_o   (off_s)
   );

   // Nothing here restarts the oscillator; only the wake leaves
   always_ff @(posedge lclk_i) begin
      if (lrst_i) begin
         wake_o <= 1'b0;
      end else if (cyc_start_i && off_s) begin
         wake_o <= 1'b1;
      end else if (!off_s) begin
         wake_o <= 1'b0;
      end
   end

   a_clkstop_five: assert property (
      @(posedge lclk_i) disable iff (lrst_i)
      (clkrun_n_i && !clkrun_q_r) ##1 clkrun_n_i [*4] |=> clkstop_o)
      else $error("clock stop not seen after five high cycles");

   a_clkstop_low: assert property (
      @(posedge lclk_i) disable iff (lrst_i)
      !clkrun_n_i |=> !clkstop_o ##1 !clkstop_o [*3])
      else $error("clock stop seen too early");

   a_wake_raise: assert property (
      @(posedge lclk_i) disable iff (lrst_i)
      (cyc_start_i && off_s) |=> wake_o)
      else $error("wake not raised for cycle while oscillator off");

endmodule

// File: logic/hiclk_top.sv
`timescale 1ns/1ns
// Behaviour
// - Request bit is the serial interrupt level when this device is chosen.
// - Throughput bit: 0 supports 33MHz only, 1 supports 24-33MHz; reset 1.
// - Two-bit policy in bits 1:0 chooses when stop is permitted; reset 0.
// - Policy 0: permit stop only while power-down line is asserted low.
// - Policy 1: permit stop on clock stop with no interrupt or DMA pending.
// - Clock stop means clock run high five bus clocks after its rise.
// - Policy 2: permit stop after each completed bus cycle.
// - Policy 3: never permit stop while interface is active.
// - Interface inactive: permit stop regardless of policy.
// - Block only grants permission, never restarts the oscillator.
// - Cycle arriving while oscillator is off raises the host wake event.
module hiclk_top
   import hiclk_pkg::*;
(
   input  wire logic                     MCLK_I,          // Controller clock
   input  wire logic                     RST_I,           // Sync reset, high
   input  wire logic                     PSEL_I,          // APB select
   input  wire logic                     PENABLE_I,       // APB enable
   input  wire logic                     PWRITE_I,        // APB write
   input  wire logic [hiclk_pkg::ADDR_W-1:0] PADDR_I,     // APB address
   input  wire logic [hiclk_pkg::DATA_W-1:0] PWDATA_I,    // APB write data
   output logic      [hiclk_pkg::DATA_W-1:0] PRDATA_O,    // APB read data
   output logic                          PREADY_O,        // APB ready
   output logic                          PSLVERR_O,       // APB error
   input  wire logic                     LPC_CLK_I,       // Bus clock
   input  wire logic                     CLKRUN_N_I,      // Clock run line
   input  wire logic                     LPCPD_N_I,       // Power-down line
   input  wire logic                     LPC_CYC_START_I, // Cycle start pulse
   input  wire logic                     LPC_CYC_DONE_I,  // Cycle done pulse
   input  wire logic                     OSC_OFF_I,       // Oscillator off
   input  wire logic                     HOST_ACTIVE_I,   // Activate bit
   input  wire logic                     SERIRQ_SEL_I,    // Chosen as source
   input  wire logic                     REQ_PENDING_I,   // IRQ or DMA pending
   output logic                          OSC_STOP_PERMIT_O, // Stop permitted
   output logic                          SERIRQ_SRC_O,    // Serial IRQ level
   output logic                          THROTTLE_WIDE_O, // 24-33MHz support
   output logic                          HOST_WAKE_O      // Host wake request
);

   import hiclk_pkg::*;

   logic              setup;
   logic              acc;
   logic              wr_acc;
   logic [DATA_W-1:0] rdata_nxt;
   logic              err_nxt;
   logic [DATA_W-1:0] prdata_r;
   logic              slverr_r;
   logic              irq_r;
   logic              hs_r;
   logic [1:0]        pol_r;
   logic              permit_r;
   logic              permit_nxt;
   logic              src_r;
   logic              lpcpd_s;
   logic              clkstop_s;
   logic              start_s;
   logic              done_s;
   logic              start_q_r;
   logic              done_q_r;
   logic              start_ev;
   logic              done_ev;
   logic              busy_r;
   logic              link_rst;
   logic              clkstop_l;
   logic              start_tgl;
   logic              done_tgl;
   logic              wake_l;
   logic              wake_s;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign setup  = PSEL_I & ~PENABLE_I;
   assign acc    = PSEL_I & PENABLE_I;
   assign wr_acc = acc & PWRITE_I;

   always_comb begin
      rdata_nxt = '0;
      err_nxt   = 1'b0;
      case (PADDR_I)
         OFF_SERIRQ: begin
            rdata_nxt[IRQ_BIT] = irq_r;
         end
         OFF_POLICY: begin
            rdata_nxt[HS_BIT]          = hs_r;
            rdata_nxt[POL_MSB:POL_LSB] = pol_r;
         end
         OFF_STATUS: begin
            rdata_nxt[ST_PERMIT]  = permit_r;
            rdata_nxt[ST_CLKSTOP] = clkstop_s;
            rdata_nxt[ST_PWRDN]   = lpcpd_s;
            rdata_nxt[ST_BUSY]    = busy_r;
            rdata_nxt[ST_WAKE]    = wake_s;
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   // Read data is caught in setup so the access phase needs no wait
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         prdata_r <= '0;
         slverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= PWRITE_I ? '0 : rdata_nxt;
         slverr_r <= err_nxt;
      end
   end

   assign PRDATA_O  = prdata_r;
   assign PREADY_O  = acc;
   assign PSLVERR_O = acc & slverr_r;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         irq_r <= RST_IRQ;
      end else if (wr_acc && PADDR_I == OFF_SERIRQ) begin
         irq_r <= PWDATA_I[IRQ_BIT];
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         hs_r  <= RST_HS;
         pol_r <= RST_POL;
      end else if (wr_acc && PADDR_I == OFF_POLICY) begin
         hs_r  <= PWDATA_I[HS_BIT];
         pol_r <= PWDATA_I[POL_MSB:POL_LSB];
      end
   end

   // Bus timing mode is consumed by the cycle engine outside
   assign THROTTLE_WIDE_O = hs_r;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         src_r <= 1'b0;
      end else begin
         src_r <= irq_r & SERIRQ_SEL_I;
      end
   end

   assign SERIRQ_SRC_O = src_r;

   // ------------------------------------------------------------
   // Crossings from the pins and the bus clock domain
   // ------------------------------------------------------------
   hiclk_sync3 u_lrst (
      .clk_i (LPC_CLK_I),
      .rst_i (1'b0),
      .d_i   (RST_I),
      .q_o   (link_rst)
   );

   hiclk_link u_link (
      .lclk_i      (LPC_CLK_I),
      .lrst_i      (link_rst),
      .clkrun_n_i  (CLKRUN_N_I),
      .cyc_start_i (LPC_CYC_START_I),
      .cyc_done_i  (LPC_CYC_DONE_I),
      .osc_off_i   (OSC_OFF_I),
      .clkstop_o   (clkstop_l),
      .start_tgl_o (start_tgl),
      .done_tgl_o  (done_tgl),
      .wake_o      (wake_l)
   );

   assign HOST_WAKE_O = wake_l;

   hiclk_sync3 u_pd (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .d_i   (~LPCPD_N_I),
      .q_o   (lpcpd_s)
   );

   hiclk_sync3 u_stop (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .d_i   (clkstop_l),
      .q_o   (clkstop_s)
   );

   hiclk_sync3 u_start (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .d_i   (start_tgl),
      .q_o   (start_s)
   );

   hiclk_sync3 u_done (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .d_i   (done_tgl),
      .q_o   (done_s)
   );

   hiclk_sync3 u_wake (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .d_i   (wake_l),
      .q_o   (wake_s)
   );

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         start_q_r <= 1'b0;
         done_q_r  <= 1'b0;
      end else begin
         start_q_r <= start_s;
         done_q_r  <= done_s;
      end
   end

   assign start_ev = start_s ^ start_q_r;
   assign done_ev  = done_s ^ done_q_r;

   // Both at once means a whole short cycle went by: idle
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         busy_r <= 1'b0;
      end else if (done_ev) begin
         busy_r <= 1'b0;
      end else if (start_ev) begin
         busy_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Stop permission
   // ------------------------------------------------------------
   always_comb begin
      if (!HOST_ACTIVE_I) begin
         permit_nxt = 1'b1;
      end else begin
         case (pol_r)
            POL_PWRDN: begin
               permit_nxt = lpcpd_s;
            end
            POL_CLKRUN: begin
               permit_nxt = clkstop_s & ~REQ_PENDING_I;
            end
            POL_TXN: begin
               permit_nxt = ~busy_r;
            end
            POL_NEVER: begin
               permit_nxt = 1'b0;
            end
            default: begin
               permit_nxt = 1'b0;
            end
         endcase
      end
   end

   // A grant only; the oscillator restarts through the wake path
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         permit_r <= 1'b0;
      end else begin
         permit_r <= permit_nxt;
      end
   end

   assign OSC_STOP_PERMIT_O = permit_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_irq_level: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (wr_acc && PADDR_I == OFF_SERIRQ && PWDATA_I[IRQ_BIT])
      ##1 SERIRQ_SEL_I |=> SERIRQ_SRC_O)
      else $error("serial irq level does not follow request bit");

   a_hs_write: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (wr_acc && PADDR_I == OFF_POLICY)
      |=> THROTTLE_WIDE_O == $past(PWDATA_I[HS_BIT]))
      else $error("throughput bit not written");

   a_pol_write: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (wr_acc && PADDR_I == OFF_POLICY)
      |=> pol_r == $past(PWDATA_I[POL_MSB:POL_LSB]))
      else $error("policy field not written");

   a_pwrdn_permit: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (HOST_ACTIVE_I && pol_r == POL_PWRDN)
      |=> OSC_STOP_PERMIT_O == $past(lpcpd_s))
      else $error("policy 0 permit does not follow power-down");

   a_clkrun_block: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (HOST_ACTIVE_I && pol_r == POL_CLKRUN
       && (REQ_PENDING_I || !clkstop_s)) |=> !OSC_STOP_PERMIT_O)
      else $error("policy 1 permit while pending or clock running");

   a_txn_permit: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (HOST_ACTIVE_I && pol_r == POL_TXN && done_ev)
      ##1 (HOST_ACTIVE_I && pol_r == POL_TXN && !start_ev)
      |=> OSC_STOP_PERMIT_O)
      else $error("policy 2 no permit after completed cycle");

   a_never_permit: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      (HOST_ACTIVE_I && pol_r == POL_NEVER) |=> !OSC_STOP_PERMIT_O)
      else $error("policy 3 permitted stop");

   a_inactive_permit: assert property (
      @(posedge MCLK_I) disable iff (RST_I)
      !HOST_ACTIVE_I |=> OSC_STOP_PERMIT_O)
      else $error("inactive interface did not permit stop");

   a_reset_values: assert property (
      @(posedge MCLK_I)
      RST_I |=> (!irq_r && pol_r == RST_POL && THROTTLE_WIDE_O))
      else $error("register reset values wrong");

endmodule

// File: tb/hiclk_lpc_host.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host chipset side of the bus; it never touches the activate bit
// ---------------------------------------------------------------
module hiclk_lpc_host (
   input  wire logic lclk_i,       // Bus clock
   output logic      clkrun_n_o,   // Clock run line
   output logic      lpcpd_n_o,    // Power-down line, active low
   output logic      cyc_start_o,  // Cycle detected pulse
   output logic      cyc_done_o    // Cycle completed pulse
);
   initial begin
      clkrun_n_o  = 1'b0;
      lpcpd_n_o   = 1'b1;
      cyc_start_o = 1'b0;
      cyc_done_o  = 1'b0;
   end

   // High for n bus clocks, then low again unless told to stay
   task automatic clkrun_stop(input int n, input bit stay);
      @(posedge lclk_i);
      clkrun_n_o <= 1'b1;
      repeat (n) @(posedge lclk_i);
      if (!stay) begin
         clkrun_n_o <= 1'b0;
      end
   endtask

   task automatic clkrun_run();
      @(posedge lclk_i);
      clkrun_n_o <= 1'b0;
   endtask

   task automatic power_down(input bit on);
      @(posedge lclk_i);
      lpcpd_n_o <= !on;
   endtask

   // One bus clock pulse; start and end kept apart by the caller
   task automatic cyc_pulse(input bit done);
      @(posedge lclk_i);
      if (done) begin
         cyc_done_o <= 1'b1;
      end else begin
         cyc_start_o <= 1'b1;
      end
      @(posedge lclk_i);
      cyc_start_o <= 1'b0;
      cyc_done_o  <= 1'b0;
   endtask
endmodule

// File: tb/hiclk_top_tb.sv
`timescale 1ns/1ns
module hiclk_top_tb;
   import hiclk_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic              mclk;
   logic              lclk;
   logic              rst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   logic              clkrun_n;
   logic              lpcpd_n;
   logic              cyc_start;
   logic              cyc_done;
   logic              osc_off;
   logic              active;
   logic              sel;
   logic              pending;
   logic              permit;
   logic              irq_src;
   logic              wide;
   logic              wake;
   logic              seen;
   logic              seen_clr;
   logic [DATA_W-1:0] rd;
   logic              err;
   int                n_errors;
   int                samples_checked;

   hiclk_top i_hiclk_top (
      .MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .LPC_CLK_I(lclk), .CLKRUN_N_I(clkrun_n), .LPCPD_N_I(lpcpd_n),
      .LPC_CYC_START_I(cyc_start), .LPC_CYC_DONE_I(cyc_done),
      .OSC_OFF_I(osc_off), .HOST_ACTIVE_I(active), .SERIRQ_SEL_I(sel),
      .REQ_PENDING_I(pending), .OSC_STOP_PERMIT_O(permit),
      .SERIRQ_SRC_O(irq_src), .THROTTLE_WIDE_O(wide),
      .HOST_WAKE_O(wake));

   hiclk_lpc_host i_hiclk_lpc_host (
      .lclk_i(lclk), .clkrun_n_o(clkrun_n), .lpcpd_n_o(lpcpd_n),
      .cyc_start_o(cyc_start), .cyc_done_o(cyc_done));

   // ------------------------------------------------------------
   // Clocks; bus clock period 125 ns, odd phase
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever begin
         #62 lclk = 1'b1;
         #63 lclk = 1'b0;
      end
   end

   // Catches even a brief permit pulse between checks
   always @(posedge mclk) begin
      seen <= seen_clr ? 1'b0 : (seen | (permit === 1'b1));
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      // Only the watchdog ends a wait that never sees ready
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1);
      check(n, 1, "wait states");
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
      apb(1'b0, a, 32'h0);
      check(rd, exp, what);
      check(err, 1'b0, "read error");
   endtask

   task automatic settle();
      repeat (24) @(posedge mclk);
   endtask

   task automatic do_reset(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (12000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      osc_off = 1'b0;
      active = 1'b1;
      sel = 1'b0;
      pending = 1'b0;
      seen_clr = 1'b1;
      n_errors = 0;
      samples_checked = 0;
      do_reset(6);
      check(wide, 1'b1, "wide after reset");
      rdc(OFF_SERIRQ, 32'h0, "irq reg reset");
      rdc(OFF_POLICY, 32'h4, "policy reg reset");
      // Reserved bits must read back as zero
      apb(1'b1, OFF_SERIRQ, 32'hFFFFFFFF);
      rdc(OFF_SERIRQ, 32'h1, "irq reg");
      sel <= 1'b1;
      repeat (2) @(posedge mclk);
      check(irq_src, 1'b1, "irq level");
      sel <= 1'b0;
      repeat (2) @(posedge mclk);
      check(irq_src, 1'b0, "irq unselected");
      sel <= 1'b1;
      apb(1'b1, OFF_SERIRQ, 32'h0);
      repeat (2) @(posedge mclk);
      check(irq_src, 1'b0, "irq cleared");
      apb(1'b1, OFF_POLICY, 32'hFFFFFFF8);
      repeat (2) @(posedge mclk);
      check(wide, 1'b0, "narrow clock");
      rdc(OFF_POLICY, 32'h0, "policy reg");
      apb(1'b0, 8'h18, 32'h0);
      check(err, 1'b1, "unmapped error");
      check(rd, 32'h0, "unmapped read");
      // Power-down policy
      apb(1'b1, OFF_POLICY, 32'h4);
      settle();
      check(permit, 1'b0, "pd idle");
      i_hiclk_lpc_host.power_down(1'b1);
      settle();
      check(permit, 1'b1, "pd asserted");
      rdc(OFF_STATUS, 32'h5, "status pd");
      i_hiclk_lpc_host.power_down(1'b0);
      settle();
      check(permit, 1'b0, "pd released");
      // Clock run policy; four high clocks are not yet a stop
      apb(1'b1, OFF_POLICY, 32'h5);
      seen_clr <= 1'b1;
      @(posedge mclk);
      seen_clr <= 1'b0;
      i_hiclk_lpc_host.clkrun_stop(4, 1'b0);
      settle();
      check(seen, 1'b0, "four high clocks");
      i_hiclk_lpc_host.clkrun_stop(5, 1'b1);
      settle();
      check(permit, 1'b1, "clock stop");
      pending <= 1'b1;
      settle();
      check(permit, 1'b0, "request pending");
      pending <= 1'b0;
      settle();
      check(permit, 1'b1, "request gone");
      i_hiclk_lpc_host.clkrun_run();
      settle();
      check(permit, 1'b0, "clock running");
      // Per-transaction policy, with a cycle while oscillator is off
      apb(1'b1, OFF_POLICY, 32'h6);
      settle();
      check(permit, 1'b1, "txn idle");
      osc_off <= 1'b1;
      settle();
      i_hiclk_lpc_host.cyc_pulse(1'b0);
      settle();
      check({wake, permit}, 2'b10, "cycle while off");
      rdc(OFF_STATUS, 32'h18, "status wake");
      i_hiclk_lpc_host.cyc_pulse(1'b1);
      osc_off <= 1'b0;
      settle();
      check({wake, permit}, 2'b01, "cycle done");
      // Never policy, then interface inactive
      i_hiclk_lpc_host.power_down(1'b1);
      i_hiclk_lpc_host.clkrun_stop(5, 1'b1);
      apb(1'b1, OFF_POLICY, 32'h7);
      settle();
      check(permit, 1'b0, "never policy");
      active <= 1'b0;
      settle();
      check(permit, 1'b1, "inactive");
      active <= 1'b1;
      settle();
      check(permit, 1'b0, "active again");
      // Second reset in mid-run, long enough for the bus clock side
      apb(1'b1, OFF_SERIRQ, 32'h1);
      do_reset(16);
      check({wide, irq_src}, 2'b10, "outputs after reset");
      rdc(OFF_SERIRQ, 32'h0, "irq reg rereset");
      rdc(OFF_POLICY, 32'h4, "policy rereset");
      tally_and_finish();
   end
endmodule
